/* design/scpm_consts.svh */
`ifndef SCPM_CONSTS_SVH
`define SCPM_CONSTS_SVH

// Register byte offsets
`define SCPM_OFS_SCC 12'h000
`define SCPM_OFS_STATUS 12'h004
`define SCPM_OFS_WAKE 12'h008

// Field positions of the clock control register
`define SCPM_SCC_SEL_HI 7
`define SCPM_SCC_SEL_LO 5
`define SCPM_SCC_STABLE 3
`define SCPM_SCC_FAST_EN 2
`define SCPM_SCC_FAST_KEEP 1
`define SCPM_SCC_SLOW_KEEP 0

// Reset values and special codes
`define SCPM_SEL_RST 3'h7
`define SCPM_SEL_SLOW 3'h7
`define SCPM_WAKE_RST 8'h00
`define SCPM_PIN_RST 13'h1_ff0

// Timing: clock rate and times in their own units
`define SCPM_PCLK_MHZ 100
`define SCPM_SWITCH_NS 100
`define SCPM_FAST_STABLE_NS 2000

`endif

/* design/scpm_pkg.sv */
package scpm_pkg;

   // Operating mode of the core
   typedef enum logic [2:0] {
      SCPM_RUN,
      SCPM_SLEEP,
      SCPM_NAP_SLOW,
      SCPM_NAP_BOTH,
      SCPM_NAP_FAST
   } scpm_mode_t;

   // Software view of the clock control register
   typedef struct packed {
      logic [2:0] sysclk_select;
      logic fast_osc_enable;
      logic fast_osc_idle_keep;
      logic slow_osc_idle_keep;
   } scpm_scc_t;

   // Wake-up action handed to the core
   typedef struct packed {
      logic full_reset;
      logic pc_sp_reset;
      logic resume_next;
      logic irq_service;
   } scpm_wake_t;

endpackage

/* design/scpm_clkdiv.sv */
`timescale 1ns/100ps
`include "scpm_consts.svh"

module scpm_clkdiv (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Source edge and ratio code
   input wire logic src_edge,
   input wire logic [2:0] ratio,
   // One pulse per divided period
   output logic tick
);

   logic [5:0] cnt;
   wire [6:0] mask_w = (7'h01 << ratio) - 7'h01;
   wire [5:0] mask = mask_w[5:0];
   wire last = (cnt & mask) == mask;

   // Free counter on source edges; the mask selects the power of two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 6'h00;
         tick <= 1'b0;
      end else begin
         tick <= src_edge & last;
         if (src_edge) begin
            cnt <= cnt + 6'h01;
         end
      end
   end

endmodule

/* design/scpm_top.sv */
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "scpm_consts.svh"

module scpm_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Oscillators and pins, asynchronous
   input wire logic hi_speed_clock,
   input wire logic low_speed_clock,
   input wire logic fast_osc_ready,
   input wire logic slow_osc_ready,
   input wire logic external_clear_pin_n,
   input wire logic [7:0] porta_pin,
   // Core events, same clock
   input wire logic halt_exec,
   input wire logic clr_wdt_exec,
   input wire logic fast_osc_freq_change,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] irq_enable,
   input wire logic stack_full,
   input wire logic wdog_enable,
   input wire logic wdog_overflow,
   // Clock outputs
   output logic sys_tick,
   output logic periph_fast_tick,
   output logic periph_slow_tick,
   output logic fast_osc_run,
   output logic slow_osc_run,
   output logic wdog_osc_run,
   // Core control outputs
   output logic cpu_halted,
   output logic wdog_clear,
   output logic wdog_run,
   output logic full_reset_req,
   output logic pc_sp_reset,
   output logic resume_next,
   output logic irq_service,
   output logic power_down_flag,
   output logic wdog_expiry_flag
);

   // Cycle counts derived from times; least times round up
   localparam int SWITCH_CYC_I = (`SCPM_SWITCH_NS * `SCPM_PCLK_MHZ + 999) / 1000;
   localparam int STABLE_CYC_I = (`SCPM_FAST_STABLE_NS * `SCPM_PCLK_MHZ + 999) / 1000;
   localparam logic [7:0] SWITCH_LAST = 8'(SWITCH_CYC_I - 1);
   localparam logic [9:0] STABLE_LAST = 10'(STABLE_CYC_I - 1);

   scpm_pkg::scpm_scc_t system_clock_control;
   scpm_pkg::scpm_mode_t mode;
   scpm_pkg::scpm_mode_t next_mode;
   scpm_pkg::scpm_wake_t next_wake;
   logic fast_stable;
   logic [7:0] wake_en;
   logic [2:0] active_sel;
   logic [7:0] sw_cnt;
   logic [9:0] stab_cnt;
   logic [7:0] irq_armed;
   logic [12:0] pin_s1;
   logic [12:0] pin_s2;
   logic [12:0] pin_s3;

   // Pin synchroniser; levels are taken from the second stage, edges from the second and third
   wire [12:0] pin_raw = {porta_pin, external_clear_pin_n, slow_osc_ready, fast_osc_ready,
                          low_speed_clock, hi_speed_clock};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= `SCPM_PIN_RST;
         pin_s2 <= `SCPM_PIN_RST;
         pin_s3 <= `SCPM_PIN_RST;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // Edges and levels of the synchronised pins
   wire hi_rise = pin_s2[0] & ~pin_s3[0];
   wire lo_rise = pin_s2[1] & ~pin_s3[1];
   wire fast_ready_s = pin_s2[2];
   wire slow_ready_s = pin_s2[3];
   wire ext_fall = ~pin_s2[4] & pin_s3[4];
   wire [7:0] porta_fall = ~pin_s2[12:5] & pin_s3[12:5];

   // APB decode; one wait state; a write lands on the edge where the master sees pready
   wire apb_access = psel & penable & ~pready;
   wire apb_wr = psel & penable & pready & pwrite;
   wire hit_scc = paddr == `SCPM_OFS_SCC;
   wire hit_status = paddr == `SCPM_OFS_STATUS;
   wire hit_wake = paddr == `SCPM_OFS_WAKE;
   wire hit_any = hit_scc | hit_status | hit_wake;
   wire wr_scc = apb_wr & hit_scc;
   wire wr_wake = apb_wr & hit_wake;

   // Read views; unused bits read as zero
   wire [7:0] scc_view = {system_clock_control.sysclk_select, 1'b0, fast_stable, system_clock_control.fast_osc_enable,
                          system_clock_control.fast_osc_idle_keep, system_clock_control.slow_osc_idle_keep};
   wire switch_pending = system_clock_control.sysclk_select != active_sel;
   wire active_slow = active_sel == `SCPM_SEL_SLOW;
   wire [7:0] status_view = {1'b0, active_slow, switch_pending, 3'(mode), wdog_expiry_flag,
                             power_down_flag};
   wire [7:0] read_byte = hit_scc ? scc_view : hit_status ? status_view : hit_wake ? wake_en : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_access;
         pslverr <= apb_access & ~hit_any;
         prdata <= (apb_access & ~pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
      end
   end

   // Software registers; state is held through every low-power mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_clock_control <= '{sysclk_select: `SCPM_SEL_RST, default: 1'b0};
         wake_en <= `SCPM_WAKE_RST;
      end else begin
         if (wr_scc) begin
            system_clock_control.sysclk_select <= pwdata[`SCPM_SCC_SEL_HI:`SCPM_SCC_SEL_LO];
            system_clock_control.fast_osc_enable <= pwdata[`SCPM_SCC_FAST_EN];
            system_clock_control.fast_osc_idle_keep <= pwdata[`SCPM_SCC_FAST_KEEP];
            system_clock_control.slow_osc_idle_keep <= pwdata[`SCPM_SCC_SLOW_KEEP];
         end
         if (wr_wake) begin
            wake_en <= pwdata[7:0];
         end
      end
   end

   // Clock switch: wait a synchronising delay, then for the target source
   wire target_slow = system_clock_control.sysclk_select == `SCPM_SEL_SLOW;
   wire target_ok = target_slow ? slow_ready_s : (fast_ready_s & fast_osc_run);
   wire switch_due = switch_pending & (sw_cnt == SWITCH_LAST) & target_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_sel <= `SCPM_SEL_RST;
         sw_cnt <= 8'h00;
      end else begin
         if (!switch_pending) begin
            sw_cnt <= 8'h00;
         end else if (sw_cnt != SWITCH_LAST) begin
            sw_cnt <= sw_cnt + 8'h01;
         end
         if (switch_due) begin
            active_sel <= system_clock_control.sysclk_select;
         end
      end
   end

   // Divided fast clock; code zero to six is the power of two
   logic fast_div_tick;
   wire fast_edge = hi_rise & fast_osc_run;
   wire slow_edge = lo_rise & slow_osc_run;

   scpm_clkdiv u_fast_div (
      .pclk(pclk),
      .presetn(presetn),
      .src_edge(fast_edge),
      .ratio(active_sel),
      .tick(fast_div_tick)
   );

   // Mode decode
   wire in_run = mode == scpm_pkg::SCPM_RUN;
   wire in_sleep = mode == scpm_pkg::SCPM_SLEEP;
   wire in_nap_slow = mode == scpm_pkg::SCPM_NAP_SLOW;
   wire in_nap_both = mode == scpm_pkg::SCPM_NAP_BOTH;
   wire in_nap_fast = mode == scpm_pkg::SCPM_NAP_FAST;
   wire halt_take = halt_exec & in_run;

   // System tick only while the core runs; switch happens between ticks
   wire next_sys_tick = in_run & (active_slow ? slow_edge : fast_div_tick);

   // Oscillator requests per mode
   wire fast_run_run = system_clock_control.fast_osc_enable | ~active_slow;
   wire fast_run_nap = (in_nap_both | in_nap_fast) & system_clock_control.fast_osc_idle_keep;
   wire next_fast_run = in_run ? fast_run_run : fast_run_nap;
   wire slow_run_nap = (in_nap_slow | in_nap_both) & system_clock_control.slow_osc_idle_keep;
   wire next_slow_run = in_run | slow_run_nap;
   wire next_wdog_osc = next_slow_run | wdog_enable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_tick <= 1'b0;
         periph_fast_tick <= 1'b0;
         periph_slow_tick <= 1'b0;
         fast_osc_run <= 1'b0;
         slow_osc_run <= 1'b0;
         wdog_osc_run <= 1'b0;
      end else begin
         sys_tick <= next_sys_tick;
         periph_fast_tick <= fast_edge;
         periph_slow_tick <= slow_edge;
         fast_osc_run <= next_fast_run;
         slow_osc_run <= next_slow_run;
         wdog_osc_run <= next_wdog_osc;
      end
   end

   // Stable flag restarts when the oscillator is turned on or retuned
   wire fast_restart = (next_fast_run & ~fast_osc_run) | fast_osc_freq_change;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_stable <= 1'b0;
         stab_cnt <= 10'h000;
      end else if (fast_restart) begin
         fast_stable <= 1'b0;
         stab_cnt <= 10'h000;
      end else if (!fast_osc_run | !fast_ready_s) begin
         fast_stable <= fast_stable & fast_osc_run;
         stab_cnt <= 10'h000;
      end else if (!fast_stable) begin
         stab_cnt <= stab_cnt + 10'h001;
         fast_stable <= stab_cnt == STABLE_LAST;
      end
   end

   // Wake sources; interrupts already pending at entry are disarmed
   wire [7:0] irq_wake_vec = irq_req & irq_armed;
   wire porta_wake = |(porta_fall & wake_en);
   wire irq_wake = |irq_wake_vec;
   wire irq_can_serve = (|(irq_wake_vec & irq_enable)) & ~stack_full;
   wire wake_any = porta_wake | ext_fall | irq_wake | wdog_overflow;

   // Halt mode choice from the two keep bits
   always_comb begin
      next_mode = mode;
      if (halt_take) begin
         unique case ({system_clock_control.fast_osc_idle_keep, system_clock_control.slow_osc_idle_keep})
            2'b00: next_mode = scpm_pkg::SCPM_SLEEP;
            2'b01: next_mode = scpm_pkg::SCPM_NAP_SLOW;
            2'b11: next_mode = scpm_pkg::SCPM_NAP_BOTH;
            2'b10: next_mode = scpm_pkg::SCPM_NAP_FAST;
         endcase
      end else if (!in_run & wake_any) begin
         next_mode = scpm_pkg::SCPM_RUN;
      end
   end

   // Wake action, highest priority first: pin reset, watchdog, interrupt, port
   always_comb begin
      next_wake = '0;
      if (ext_fall) begin
         next_wake.full_reset = 1'b1;
      end else if (!in_run & wdog_overflow) begin
         next_wake.pc_sp_reset = 1'b1;
      end else if (!in_run & irq_wake) begin
         next_wake.irq_service = irq_can_serve;
         next_wake.resume_next = ~irq_can_serve;
      end else if (!in_run & porta_wake) begin
         next_wake.resume_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= scpm_pkg::SCPM_RUN;
         irq_armed <= 8'h00;
         cpu_halted <= 1'b0;
         full_reset_req <= 1'b0;
         pc_sp_reset <= 1'b0;
         resume_next <= 1'b0;
         irq_service <= 1'b0;
      end else begin
         mode <= next_mode;
         if (halt_take) begin
            irq_armed <= ~irq_req;
         end
         cpu_halted <= next_mode != scpm_pkg::SCPM_RUN;
         full_reset_req <= next_wake.full_reset;
         pc_sp_reset <= next_wake.pc_sp_reset;
         resume_next <= next_wake.resume_next;
         irq_service <= next_wake.irq_service;
      end
   end

   // Status flags; a set in the same cycle as a clear wins
   wire next_pdf = halt_take | (power_down_flag & ~clr_wdt_exec);
   wire next_tof = wdog_overflow | (wdog_expiry_flag & ~halt_take);

   // Watchdog handling; the counter itself lives outside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_down_flag <= 1'b0;
         wdog_expiry_flag <= 1'b0;
         wdog_clear <= 1'b0;
         wdog_run <= 1'b0;
      end else begin
         power_down_flag <= next_pdf;
         wdog_expiry_flag <= next_tof;
         wdog_clear <= halt_take | clr_wdt_exec;
         wdog_run <= wdog_enable;
      end
   end

endmodule

/* verification/scpm_osc_model.sv */
`timescale 1ns/100ps
module scpm_osc_model (
   // Run requests from the block
   input wire logic fast_osc_run,
   input wire logic slow_osc_run,
   // Waves and settled levels
   output logic hi_speed_clock,
   output logic low_speed_clock,
   output logic fast_osc_ready,
   output logic slow_osc_ready
);
   initial begin
      hi_speed_clock = 1'b0;
      low_speed_clock = 1'b0;
      fast_osc_ready = 1'b0;
      slow_osc_ready = 1'b0;
   end
   // A stopped source stands still, so it gives no edges at all
   always #40 hi_speed_clock = fast_osc_run ? !hi_speed_clock : hi_speed_clock;
   always #150 low_speed_clock = slow_osc_run ? !low_speed_clock : low_speed_clock;
   // Settling takes time after each start; ready drops at once on a stop
   always @(fast_osc_run) begin
      fast_osc_ready = 1'b0;
      #500 fast_osc_ready = fast_osc_run;
   end
   always @(slow_osc_run) begin
      slow_osc_ready = 1'b0;
      #500 slow_osc_ready = slow_osc_run;
   end
endmodule

/* verification/scpm_top_properties.sv */
`timescale 1ns/100ps
module scpm_top_properties (
   // Clock, reset and bus handshake
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Core events
   input wire logic halt_exec,
   input wire logic clr_wdt_exec,
   input wire logic wdog_enable,
   input wire logic wdog_overflow,
   input wire logic external_clear_pin_n,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] irq_enable,
   input wire logic stack_full,
   // Block outputs
   input wire logic cpu_halted,
   input wire logic wdog_clear,
   input wire logic wdog_run,
   input wire logic full_reset_req,
   input wire logic pc_sp_reset,
   input wire logic irq_service,
   input wire logic power_down_flag,
   input wire logic wdog_expiry_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answer, halt entry, watchdog control and the wake paths
   property p_apb_wait; psel && penable && !pready |=> pready ##1 !pready; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("bus answer out of step");
   property p_halt_flags; halt_exec && !cpu_halted && !wdog_overflow |=> cpu_halted && power_down_flag && !wdog_expiry_flag; endproperty
   a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
   property p_halt_wdclr; halt_exec && !cpu_halted |=> wdog_clear; endproperty
   a_halt_wdclr: assert property (p_halt_wdclr) else $error("watchdog not cleared on halt");
   property p_wdrun; $past(presetn) |-> wdog_run == $past(wdog_enable); endproperty
   a_wdrun: assert property (p_wdrun) else $error("watchdog run not following enable");
   property p_clrwdt; clr_wdt_exec && !halt_exec |=> !power_down_flag; endproperty
   a_clrwdt: assert property (p_clrwdt) else $error("power-down flag not cleared");
   property p_wdog_wake; cpu_halted && wdog_overflow |=> pc_sp_reset && wdog_expiry_flag && !cpu_halted; endproperty
   a_wdog_wake: assert property (p_wdog_wake) else $error("watchdog wake wrong");
   property p_irq_wake; cpu_halted && !wdog_overflow && !stack_full && |(irq_req & ~$past(irq_req) & irq_enable)
      |=> irq_service && !cpu_halted; endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake wrong");
   property p_pin_reset; $fell(external_clear_pin_n) |-> ##[1:5] full_reset_req; endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pin reset not requested");
   c_halt: cover property (halt_exec && !cpu_halted);
   c_wdog: cover property (cpu_halted && wdog_overflow);
   c_irq: cover property (irq_service);
endmodule
bind scpm_top scpm_top_properties u_props (.*);

/* verification/test_sysclk_power_mode_ctrl.sv */
`timescale 1ns/100ps
module test_sysclk_power_mode_ctrl;
   // Design inputs, named as the ports
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halt_exec = 1'b0;
   logic clr_wdt_exec = 1'b0, fast_osc_freq_change = 1'b0, stack_full = 1'b0, wdog_enable = 1'b1;
   logic wdog_overflow = 1'b0, external_clear_pin_n = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [7:0] porta_pin = 8'hff, irq_req = 8'h00, irq_enable = 8'h00;
   logic hi_speed_clock, low_speed_clock, fast_osc_ready, slow_osc_ready, pready, pslverr, sys_tick;
   logic periph_fast_tick, periph_slow_tick, fast_osc_run, slow_osc_run, wdog_osc_run, cpu_halted;
   logic wdog_clear, wdog_run, full_reset_req, pc_sp_reset, resume_next, irq_service;
   logic power_down_flag, wdog_expiry_flag, errq;
   logic [31:0] prdata, rdq, m, e;
   logic [31:0] exp_rd[$], exp_msk[$], exp_wk[$];
   int fail_count = 0, comparisons = 0, cyc = 0, seed, c, k, b, nf, ns;
   int mode_of[4] = '{1, 2, 4, 3};
   int wake_of[4] = '{1, 2, 4, 2};
   scpm_top dut_u (.*);
   scpm_osc_model osc_u (.*);
   // 100 MHz bus clock
   always #5 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Bus cycle: request held until pready is seen high
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdq = prdata;
      errq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] ev, input logic [31:0] mv);
      exp_rd.push_back(ev);
      exp_msk.push_back(mv);
      apb(a, 1'b0, 32'h0000_0000);
   endtask
   // A zero mask marks a poll, which is not compared
   task poll(input logic [11:0] a, input logic [31:0] mv, input logic [31:0] v);
      do rd(a, 32'h0000_0000, 32'h0000_0000); while ((rdq & mv) !== v);
   endtask
   // Results are matched against the oldest note as they appear
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (pready === 1'b1 && pwrite === 1'b0 && exp_msk.size() > 0) begin
         m = exp_msk.pop_front();
         e = exp_rd.pop_front();
         if (m != 32'h0000_0000) chk(prdata & m, e & m);
      end
      if ({full_reset_req, pc_sp_reset, resume_next, irq_service} !== 4'h0) begin
         e = (exp_wk.size() > 0) ? exp_wk.pop_front() : 32'h0000_0000;
         chk({28'h000_0000, full_reset_req, pc_sp_reset, resume_next, irq_service}, e);
      end
      if (cyc == 40000) begin
         fail_count++;
         final_report;
      end
   end
   initial begin
      seed = 55627;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 32'h0000_00e0, 32'hffff_ffff);
      rd(12'h008, 32'h0000_0000, 32'hffff_ffff);
      rd(12'h00c, 32'h0000_0000, 32'hffff_ffff);
      chk(errq, 1'b1);
      // Fast codes: system ticks against fast source ticks
      for (c = 0; c < 3; c++) begin
         apb(12'h000, 1'b1, 32'h0000_0004 | (c << 5));
         if (c == 0) rd(12'h000, 32'h0000_0004, 32'h0000_00ff);
         poll(12'h004, 32'h0000_0060, 32'h0000_0000);
         nf = 0;
         ns = 0;
         while (nf < 64) begin
            @(posedge pclk);
            nf += periph_fast_tick;
            ns += sys_tick;
         end
         chk(ns + 1 >= (64 >> c) && ns <= (64 >> c) + 1, 1'b1);
      end
      poll(12'h000, 32'h0000_0008, 32'h0000_0008);
      fast_osc_freq_change <= 1'b1;
      @(posedge pclk);
      fast_osc_freq_change <= 1'b0;
      rd(12'h000, 32'h0000_0044, 32'h0000_00ff);
      apb(12'h000, 1'b1, 32'h0000_00e4);
      poll(12'h004, 32'h0000_0060, 32'h0000_0040);
      chk(fast_osc_run, 1'b1);
      apb(12'h000, 1'b1, 32'h0000_00e0);
      repeat (3) @(posedge pclk);
      chk(fast_osc_run, 1'b0);
      // Each keep setting, woken by interrupt (twice, once with the stack full), watchdog or port pin
      for (k = 0; k < 4; k++) begin
         b = $random(seed) & 7;
         wdog_enable <= 1'($random(seed));
         irq_enable <= 8'h01;
         irq_req <= (k == 0) ? 8'h02 : 8'h00;
         apb(12'h008, 1'b1, 32'h0000_0001 << b);
         apb(12'h000, 1'b1, 32'h0000_00e0 | k);
         @(posedge pclk);
         halt_exec <= 1'b1;
         @(posedge pclk);
         halt_exec <= 1'b0;
         repeat (8) @(posedge pclk);
         chk(cpu_halted, 1'b1);
         chk(fast_osc_run, k[1]);
         chk(slow_osc_run, k[0]);
         chk(wdog_osc_run, k[0] | wdog_enable);
         rd(12'h004, 32'h0000_0041 | (mode_of[k] << 2), 32'h0000_007f);
         rd(12'h000, 32'h0000_00e0 | k, 32'h0000_00f7);
         stack_full <= (k == 1);
         exp_wk.push_back(wake_of[k]);
         case (k)
            0, 1: irq_req <= irq_req | 8'h01;
            2: wdog_overflow <= 1'b1;
            default: porta_pin <= ~(8'h01 << b);
         endcase
         @(posedge pclk);
         wdog_overflow <= 1'b0;
         repeat (6) @(posedge pclk);
         chk(cpu_halted, 1'b0);
         irq_req <= 8'h00;
         porta_pin <= 8'hff;
      end
      clr_wdt_exec <= 1'b1;
      @(posedge pclk);
      clr_wdt_exec <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(power_down_flag, 1'b0);
      exp_wk.push_back(32'h0000_0008);
      external_clear_pin_n <= 1'b0;
      repeat (8) @(posedge pclk);
      external_clear_pin_n <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(exp_wk.size(), 32'h0000_0000);
      final_report;
   end
endmodule
